/* File: rtl/asoc_pkg.sv */
// Package of constants and types for the converter serial output control block
package asoc_pkg;
   // ------------------------------------------------------------
   // Word format
   // ------------------------------------------------------------
   localparam int ASOC_WORD_W = 16;
   localparam logic [15:0] ASOC_POS_FULL = 16'h7FFF;
   localparam logic [15:0] ASOC_NEG_FULL = 16'h8000;
   localparam logic [15:0] ASOC_ZERO = 16'h0000;
   // ------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------
   localparam int ASOC_DECIM = 16;
   localparam int ASOC_SETTLE_CONV = 51;
   localparam int ASOC_FIFO_DEPTH = 8;
   localparam int ASOC_SAMPLE_W = 18;
   // ------------------------------------------------------------
   // Link state machine
   // ------------------------------------------------------------
   typedef enum logic [1:0] {
      ASOC_ST_IDLE,
      ASOC_ST_SETTLE,
      ASOC_ST_RUN
   } asoc_state_e;
endpackage : asoc_pkg

/* File: rtl/asoc_fifo.sv */
// Word FIFO between the sample formatter and the serial shifter
`timescale 1ns/10ps
`default_nettype none
module asoc_fifo #(
   parameter int WIDTH = 17,
   parameter int DEPTH = 8
) (
   input wire logic clk_i,
   input wire logic sys_rst_i,
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [WIDTH-1:0] in_data_i,
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [WIDTH-1:0] out_data_o
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [AW-1:0] wr_r, wr_nxt, rd_r, rd_nxt;
   logic [AW:0] cnt_r, cnt_nxt;
   logic [WIDTH-1:0] dout_r, dout_nxt;
   logic vld_r, vld_nxt;
   logic push, pop;

   // ------------------------------------------------------------
   // Pointer and count update
   // ------------------------------------------------------------
   always_comb begin
      push = in_valid_i && (cnt_r != (AW+1)'(DEPTH));
      pop = (cnt_r != '0) && (!vld_r || out_ready_i);
      wr_nxt = push ? ((wr_r == AW'(DEPTH-1)) ? '0 : wr_r + 1'b1) : wr_r;
      rd_nxt = pop ? ((rd_r == AW'(DEPTH-1)) ? '0 : rd_r + 1'b1) : rd_r;
      cnt_nxt = cnt_r + (AW+1)'(push) - (AW+1)'(pop);
      dout_nxt = pop ? mem_r[rd_r] : dout_r;
      vld_nxt = pop ? 1'b1 : (out_ready_i ? 1'b0 : vld_r);
   end

   always_ff @(posedge clk_i) begin
      if (push) begin
         mem_r[wr_r] <= in_data_i;
      end
      if (sys_rst_i) begin
         wr_r <= '0;
         rd_r <= '0;
         cnt_r <= '0;
         dout_r <= '0;
         vld_r <= 1'b0;
      end else begin
         wr_r <= wr_nxt;
         rd_r <= rd_nxt;
         cnt_r <= cnt_nxt;
         dout_r <= dout_nxt;
         vld_r <= vld_nxt;
      end
   end

   assign in_ready_o = (cnt_r != (AW+1)'(DEPTH));
   assign out_valid_o = vld_r;
   assign out_data_o = dout_r;
endmodule : asoc_fifo
`default_nettype wire

/* File: rtl/asoc_top.sv */
// Serial output control of a delta-sigma converter: format, clip, frame and shift
`timescale 1ns/10ps
`default_nettype none
module asoc_top
   import asoc_pkg::*;
#(
   parameter int SAMPLE_W = ASOC_SAMPLE_W,
   parameter int DECIM = ASOC_DECIM,
   parameter int SETTLE_CONV = ASOC_SETTLE_CONV,
   parameter int FIFO_DEPTH = ASOC_FIFO_DEPTH
) (
   input wire logic clk_i,
   input wire logic sys_rst_i,
   input wire logic master_clk_i,
   input wire logic sync_i,
   input wire logic power_down_n_i,
   input wire logic signed [SAMPLE_W-1:0] sample_i,
   output logic frame_strobe_out_o,
   output logic frame_strobe_out_n_o,
   output logic serial_clk_o,
   output logic serial_clk_n_o,
   output logic serial_data_o,
   output logic serial_data_n_o,
   output logic overrange_flag_o,
   output logic fifo_overflow_o
);
   localparam int CW = $clog2(DECIM);
   localparam int SW = $clog2(SETTLE_CONV + 1);
   localparam int BW = $clog2(ASOC_WORD_W + 1);
   localparam logic signed [SAMPLE_W-1:0] POS_LIM = SAMPLE_W'(signed'(ASOC_POS_FULL));
   localparam logic signed [SAMPLE_W-1:0] NEG_LIM = SAMPLE_W'(signed'(ASOC_NEG_FULL));

   // ------------------------------------------------------------
   // Input synchronisers and master clock edge detection
   // ------------------------------------------------------------
   logic [1:0] mck_s_r, sync_s_r, pd_s_r;
   logic [SAMPLE_W-1:0] smp_s1_r, smp_s2_r;
   logic mck_d_r, sync_d_r;
   logic mck_rise, mck_fall;

   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         mck_s_r <= '0;
         sync_s_r <= '0;
         // Power-down input rests high, so reset leaves the device awake
         pd_s_r <= '1;
         smp_s1_r <= '0;
         smp_s2_r <= '0;
         mck_d_r <= 1'b0;
         sync_d_r <= 1'b0;
      end else begin
         mck_s_r <= {mck_s_r[0], master_clk_i};
         sync_s_r <= {sync_s_r[0], sync_i};
         pd_s_r <= {pd_s_r[0], power_down_n_i};
         smp_s1_r <= sample_i;
         smp_s2_r <= smp_s1_r;
         mck_d_r <= mck_s_r[1];
         sync_d_r <= sync_s_r[1];
      end
   end

   assign mck_rise = mck_s_r[1] && !mck_d_r;
   assign mck_fall = !mck_s_r[1] && mck_d_r;

   // ------------------------------------------------------------
   // Conversion sequencing: sync, settle, run
   // ------------------------------------------------------------
   asoc_state_e state_r, state_nxt;
   logic [CW-1:0] dec_r, dec_nxt;
   logic [SW-1:0] settle_r, settle_nxt;
   logic sync_hi_r, sync_hi_nxt;
   logic inited_r, inited_nxt;
   logic conv_done;

   // Sync seen high at one master rise and low at the next restarts settling
   always_comb begin
      state_nxt = state_r;
      dec_nxt = dec_r;
      settle_nxt = settle_r;
      sync_hi_nxt = sync_hi_r;
      inited_nxt = inited_r;
      conv_done = 1'b0;
      if (!pd_s_r[1]) begin
         // Conversions halt; the sync state is kept for the wake-up
         state_nxt = inited_r ? ASOC_ST_SETTLE : ASOC_ST_IDLE;
         dec_nxt = '0;
         settle_nxt = '0;
      end else if (mck_rise) begin
         // Sync is sampled once at each master clock rise; one high sample is enough
         sync_hi_nxt = sync_d_r;
         if (sync_d_r) begin
            dec_nxt = '0;
            settle_nxt = '0;
            state_nxt = ASOC_ST_IDLE;
         end else begin
            if (state_r == ASOC_ST_IDLE && sync_hi_r) begin
               inited_nxt = 1'b1;
               state_nxt = ASOC_ST_SETTLE;
            end
            if (state_r != ASOC_ST_IDLE) begin
               dec_nxt = (dec_r == CW'(DECIM-1)) ? '0 : dec_r + 1'b1;
               conv_done = (dec_r == CW'(DECIM-1));
            end
            case (state_r)
               ASOC_ST_IDLE: begin
               end
               ASOC_ST_SETTLE: begin
                  if (conv_done) begin
                     settle_nxt = settle_r + 1'b1;
                     if (settle_r == SW'(SETTLE_CONV-1)) begin
                        state_nxt = ASOC_ST_RUN;
                     end
                  end
               end
               ASOC_ST_RUN: begin
               end
               default: state_nxt = ASOC_ST_IDLE;
            endcase
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         state_r <= ASOC_ST_IDLE;
         dec_r <= '0;
         settle_r <= '0;
         sync_hi_r <= 1'b0;
         inited_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         dec_r <= dec_nxt;
         settle_r <= settle_nxt;
         sync_hi_r <= sync_hi_nxt;
         inited_r <= inited_nxt;
      end
   end

   // ------------------------------------------------------------
   // Word formatting and clipping
   // ------------------------------------------------------------
   logic [ASOC_WORD_W-1:0] word;
   logic word_otr;
   logic fifo_in_ready, fifo_out_valid, fifo_out_ready;
   logic [ASOC_WORD_W:0] fifo_out_data;
   logic push;

   // Results beyond the 16-bit range clip to full scale and raise the flag
   always_comb begin
      word = smp_s2_r[ASOC_WORD_W-1:0];
      word_otr = 1'b0;
      if ($signed(smp_s2_r) > POS_LIM) begin
         word = ASOC_POS_FULL;
         word_otr = 1'b1;
      end else if ($signed(smp_s2_r) < NEG_LIM) begin
         word = ASOC_NEG_FULL;
         word_otr = 1'b1;
      end
   end

   assign push = conv_done && state_r == ASOC_ST_RUN && pd_s_r[1];

   // ------------------------------------------------------------
   // Word queue, emptied whenever conversions are not running
   // ------------------------------------------------------------
   // Words queued before a sync or a power-down are stale and must not be framed
   logic fifo_clr;

   assign fifo_clr = sys_rst_i || state_r != ASOC_ST_RUN;

   asoc_fifo #(
      .WIDTH(ASOC_WORD_W + 1),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .clk_i(clk_i),
      .sys_rst_i(fifo_clr),
      .in_valid_i(push),
      .in_ready_o(fifo_in_ready),
      .in_data_i({word_otr, word}),
      .out_valid_o(fifo_out_valid),
      .out_ready_i(fifo_out_ready),
      .out_data_o(fifo_out_data)
   );

   // ------------------------------------------------------------
   // Serial shifter: strobe, clock, data, flag
   // ------------------------------------------------------------
   logic fs_r, fs_nxt, sck_r, sck_nxt, sd_r, sd_nxt, otr_r, otr_nxt;
   logic ovf_r, ovf_nxt;
   logic [ASOC_WORD_W-1:0] shreg_r, shreg_nxt;
   logic [BW-1:0] bits_r, bits_nxt;
   logic otr_hold_r, otr_hold_nxt;

   // A word is taken only between frames: each frame is the strobe plus 16 bits
   assign fifo_out_ready = mck_rise && bits_r == '0 && pd_s_r[1];

   // Serial clock follows the master clock; data moves on its rise, the flag on its fall
   always_comb begin
      fs_nxt = fs_r;
      sck_nxt = sck_r;
      sd_nxt = sd_r;
      otr_nxt = otr_r;
      shreg_nxt = shreg_r;
      bits_nxt = bits_r;
      otr_hold_nxt = otr_hold_r;
      // Sticky: a word was lost because the queue was full at a push
      ovf_nxt = ovf_r || (push && !fifo_in_ready);
      if (!pd_s_r[1]) begin
         fs_nxt = 1'b0;
         sck_nxt = 1'b0;
         bits_nxt = '0;
      end else if (mck_rise) begin
         sck_nxt = 1'b1;
         fs_nxt = 1'b0;
         if (bits_r != '0) begin
            sd_nxt = shreg_r[ASOC_WORD_W-1];
            shreg_nxt = {shreg_r[ASOC_WORD_W-2:0], 1'b0};
            bits_nxt = bits_r - 1'b1;
         end else if (fifo_out_valid) begin
            fs_nxt = 1'b1;
            shreg_nxt = fifo_out_data[ASOC_WORD_W-1:0];
            otr_hold_nxt = fifo_out_data[ASOC_WORD_W];
            bits_nxt = BW'(ASOC_WORD_W);
         end
      end else if (mck_fall) begin
         sck_nxt = 1'b0;
         otr_nxt = otr_hold_r;
      end
   end

   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         fs_r <= 1'b0;
         sck_r <= 1'b0;
         sd_r <= 1'b0;
         otr_r <= 1'b0;
         ovf_r <= 1'b0;
         shreg_r <= ASOC_ZERO;
         bits_r <= '0;
         otr_hold_r <= 1'b0;
      end else begin
         fs_r <= fs_nxt;
         sck_r <= sck_nxt;
         sd_r <= sd_nxt;
         otr_r <= otr_nxt;
         ovf_r <= ovf_nxt;
         shreg_r <= shreg_nxt;
         bits_r <= bits_nxt;
         otr_hold_r <= otr_hold_nxt;
      end
   end

   // ------------------------------------------------------------
   // Complementary outputs, each from its own flip-flop
   // ------------------------------------------------------------
   logic fs_n_r, sck_n_r, sd_n_r;

   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         fs_n_r <= 1'b1;
         sck_n_r <= 1'b1;
         sd_n_r <= 1'b1;
      end else begin
         fs_n_r <= !fs_nxt;
         sck_n_r <= !sck_nxt;
         sd_n_r <= !sd_nxt;
      end
   end

   assign frame_strobe_out_o = fs_r;
   assign frame_strobe_out_n_o = fs_n_r;
   assign serial_clk_o = sck_r;
   assign serial_clk_n_o = sck_n_r;
   assign serial_data_o = sd_r;
   assign serial_data_n_o = sd_n_r;
   assign overrange_flag_o = otr_r;
   assign fifo_overflow_o = ovf_r;
endmodule : asoc_top
`default_nettype wire

/* File: test/asoc_top_assertions.sv */
// Concurrent checks on the serial output pins of the converter output block
`timescale 1ns/10ps
`default_nettype none
module asoc_top_checker (
   input wire logic clk_i,
   input wire logic sys_rst_i,
   input wire logic sync_i,
   input wire logic power_down_n_i,
   input wire logic frame_strobe_out_o,
   input wire logic frame_strobe_out_n_o,
   input wire logic serial_clk_o,
   input wire logic serial_clk_n_o,
   input wire logic serial_data_o,
   input wire logic serial_data_n_o,
   input wire logic overrange_flag_o,
   input wire logic fifo_overflow_o
);
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (sys_rst_i);
   // ----
   // Pin relations
   // ----
   a_strobe_copy: assert property (frame_strobe_out_n_o == !frame_strobe_out_o)
      else $error("strobe copy wrong");
   a_sclk_copy: assert property (serial_clk_n_o == !serial_clk_o)
      else $error("clock copy wrong");
   a_data_copy: assert property (serial_data_n_o == !serial_data_o)
      else $error("data copy wrong");
   a_strobe_open: assert property ($rose(frame_strobe_out_o) |-> $rose(serial_clk_o))
      else $error("strobe rose off clock rise");
   a_strobe_close: assert property ($fell(frame_strobe_out_o)
      && $past(power_down_n_i, 3) |-> $rose(serial_clk_o))
      else $error("strobe width wrong");
   a_data_rise: assert property ($changed(serial_data_o)
      && $past(power_down_n_i, 4) |-> $rose(serial_clk_o))
      else $error("data moved off clock rise");
   a_flag_fall: assert property ($changed(overrange_flag_o) |-> $fell(serial_clk_o))
      else $error("flag moved off clock fall");
   a_pd_quiet: assert property (!power_down_n_i [*8] |-> !$rose(frame_strobe_out_o))
      else $error("frame in power down");
   a_sync_quiet: assert property ($fell(sync_i) |-> !frame_strobe_out_o [*8])
      else $error("frame right after sync");
   c_frame: cover property ($rose(frame_strobe_out_o));
   c_flag: cover property ($rose(overrange_flag_o));
   c_overflow: cover property ($rose(fifo_overflow_o));
endmodule : asoc_top_checker
bind asoc_top asoc_top_checker u_chk (.clk_i, .sys_rst_i, .sync_i, .power_down_n_i,
   .frame_strobe_out_o, .frame_strobe_out_n_o, .serial_clk_o, .serial_clk_n_o,
   .serial_data_o, .serial_data_n_o, .overrange_flag_o, .fifo_overflow_o);
`default_nettype wire

/* File: test/asoc_host_model.sv */
// Host receiver model: assembles words from the serial output
`timescale 1ns/10ps
`default_nettype none
module asoc_host_model (
   input wire logic frame_i,
   input wire logic sclk_i,
   input wire logic data_i,
   output logic [15:0] word_o,
   output var int count_o
);
   logic [15:0] shift_r = 16'h0000;
   int bits = 16;
   initial begin
      word_o = 16'h0000;
      count_o = 0;
   end
   // Bits taken on the falling edge, away from the data change
   always @(negedge sclk_i) begin
      if (frame_i === 1'b1) begin
         bits = 0;
      end else if (bits < 16) begin
         shift_r = {shift_r[14:0], data_i};
         bits++;
         if (bits == 16) begin
            word_o = shift_r;
            count_o++;
         end
      end
   end
endmodule : asoc_host_model
`default_nettype wire

/* File: test/asoc_top_tb_top.sv */
// Self-checking bench for the converter serial output block
`timescale 1ns/10ps
`default_nettype none
module asoc_top_tb_top;
   import asoc_pkg::*;
   logic clk_i = 1'b0;
   logic sys_rst_i = 1'b1;
   logic master_clk_i = 1'b0;
   logic mclk_run = 1'b1;
   logic sync_i = 1'b0;
   logic power_down_n_i = 1'b1;
   logic signed [ASOC_SAMPLE_W-1:0] sample_i = '0;
   logic frame_strobe_out_o, frame_strobe_out_n_o, serial_clk_o, serial_clk_n_o;
   logic serial_data_o, serial_data_n_o, overrange_flag_o, fifo_overflow_o;
   logic [15:0] host_word;
   int host_cnt;
   int errors = 0;
   int tests_run = 0;
   localparam logic [17:0] SMP [8] = '{18'h00000, 18'h00001, 18'h3FFFF, 18'h07FFF,
      18'h38000, 18'h08000, 18'h37FFF, 18'h00005};
   localparam logic [15:0] WRD [8] = '{16'h0000, 16'h0001, 16'hFFFF, 16'h7FFF,
      16'h8000, 16'h7FFF, 16'h8000, 16'h0005};
   localparam logic [7:0] OVR = 8'h60;
   asoc_top #(.SETTLE_CONV(2)) u_dut (.clk_i, .sys_rst_i, .master_clk_i, .sync_i,
      .power_down_n_i, .sample_i, .frame_strobe_out_o, .frame_strobe_out_n_o,
      .serial_clk_o, .serial_clk_n_o, .serial_data_o, .serial_data_n_o,
      .overrange_flag_o, .fifo_overflow_o);
   asoc_host_model u_host (.frame_i(frame_strobe_out_o), .sclk_i(serial_clk_o),
      .data_i(serial_data_o), .word_o(host_word), .count_o(host_cnt));
   always #12.5 clk_i = ~clk_i;
   always begin
      #100;
      if (mclk_run) master_clk_i = ~master_clk_i;
   end
   // ----
   // Shared tasks
   // ----
   task automatic report_and_stop;
      if (errors == 0 && tests_run > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : report_and_stop
   task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
      tests_run++;
      if (seen !== exp) begin
         errors++;
         $display("[ERR] %s expected %h seen %h", name, exp, seen);
      end
   endtask : chk
   task automatic get_word(input int lim);
      int c0;
      c0 = host_cnt;
      for (int i = 0; i < lim && host_cnt == c0; i++) @(posedge clk_i);
      chk("word arrival", 16'(host_cnt != c0), 16'h0001);
   endtask : get_word
   task automatic wait_frame(output int n);
      n = 0;
      while (frame_strobe_out_o !== 1'b1 && n < 2000) begin
         @(posedge clk_i);
         n++;
      end
   endtask : wait_frame
   // ----
   // Scenarios
   // ----
   task automatic t_sync;
      int n;
      n = 0;
      repeat (200) @(posedge clk_i);
      chk("frames before sync", 16'(host_cnt), 16'h0000);
      @(negedge master_clk_i);
      @(posedge clk_i);
      sync_i <= 1'b1;
      repeat (24) @(posedge clk_i);
      sync_i <= 1'b0;
      wait_frame(n);
      chk("settle span", 16'(n >= 240 && n < 2000), 16'h0001);
   endtask : t_sync
   task automatic t_words;
      for (int k = 0; k < 8; k++) begin
         sample_i <= SMP[k];
         repeat (6) get_word(400);
         chk("word", host_word, WRD[k]);
         chk("overrange", {15'h0000, overrange_flag_o}, {15'h0000, OVR[k]});
      end
   endtask : t_words
   task automatic t_overflow;
      int n;
      n = 0;
      chk("overflow early", {15'h0000, fifo_overflow_o}, 16'h0000);
      while (fifo_overflow_o !== 1'b1 && n < 300) begin
         get_word(400);
         n++;
      end
      chk("overflow late", {15'h0000, fifo_overflow_o}, 16'h0001);
   endtask : t_overflow
   task automatic t_resync;
      int n;
      @(negedge master_clk_i);
      @(posedge clk_i);
      sync_i <= 1'b1;
      repeat (24) @(posedge clk_i);
      sync_i <= 1'b0;
      @(posedge clk_i);
      wait_frame(n);
      chk("resync settle span", 16'(n >= 240 && n < 2000), 16'h0001);
      get_word(400);
      chk("word after resync", host_word, WRD[7]);
   endtask : t_resync
   task automatic t_pd;
      int c0, n;
      power_down_n_i <= 1'b0;
      repeat (200) @(posedge clk_i);
      c0 = host_cnt;
      mclk_run = 1'b0;
      repeat (400) @(posedge clk_i);
      chk("frames in power down", 16'(host_cnt - c0), 16'h0000);
      mclk_run = 1'b1;
      power_down_n_i <= 1'b1;
      wait_frame(n);
      chk("wake settle span", 16'(n >= 240 && n < 2000), 16'h0001);
      repeat (100) get_word(400);
      chk("word after wake", host_word, WRD[7]);
   endtask : t_pd
   initial begin
      repeat (2) @(posedge clk_i);
      chk("reset pins", {8'h00, frame_strobe_out_o, frame_strobe_out_n_o, serial_clk_o,
         serial_clk_n_o, serial_data_o, serial_data_n_o, overrange_flag_o,
         fifo_overflow_o}, 16'h0054);
      sys_rst_i <= 1'b0;
      t_sync;
      t_words;
      t_overflow;
      t_resync;
      t_pd;
      report_and_stop;
   end
   initial begin
      repeat (90000) @(posedge clk_i);
      errors++;
      report_and_stop;
   end
endmodule : asoc_top_tb_top
`default_nettype wire
